// *** hw/actfw_device.sv ***
// Purpose: channel-1 task file window, target side
// Assumes: host holds a request until ack; drive side acks cycles
// Notes: buffered alias field writes queue until the command byte
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module actfw_device
   import actfw_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Target link
   actfw_if.dev link,
   // Drive register cycles
   output logic ataReq,
   output logic ataWr,
   output logic ataCtl,
   output logic [2:0] ataAddr,
   output logic [1:0] ataSize,
   output logic [31:0] ataWdata,
   input wire logic ataAck,
   input wire logic [31:0] ataRdata,
   // Status
   output logic bufferedActive
);

   // ====
   // State
   typedef struct packed {
      actfw_dev_state_t state;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic ataReq;
      logic ataWr;
      logic ataCtl;
      logic [2:0] ataAddr;
      logic [1:0] ataSize;
      logic [31:0] ataWdata;
      logic [1:0] lane;
      logic isData;
      logic [7:0][10:0] cmdBuf;
      logic [3:0] bufCount;
      logic [3:0] bufIdx;
      logic bufActive;
   } actfw_dev_t;

   localparam actfw_dev_t DEV_RESET = '{state: DV_IDLE, default: '0};

   actfw_dev_t devReg;
   actfw_dev_t devNext;
   actfw_dec_t dec;

   // ====
   // Access decode
   function automatic logic [1:0] laneOf(input logic [3:0] be);
      case (be)
         4'h2: laneOf = 2'h1;
         4'h4: laneOf = 2'h2;
         4'h8: laneOf = 2'h3;
         default: laneOf = 2'h0;
      endcase
   endfunction : laneOf

   function automatic actfw_dec_t decodeAccess(input logic [7:0] off,
                                               input logic [3:0] be);
      actfw_dec_t d;
      logic single;
      logic cb;
      d = '0;
      single = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) ||
               (be == 4'h8);
      cb = (off == `ACTFW_CB_A_OFF) || (off == `ACTFW_CB_B_OFF); // [R13]
      d.buffered = cb;
      case (off)
         `ACTFW_TF_A_OFF, `ACTFW_CB_A_OFF: begin
            d.ok = 1'b1;
            d.isData = 1'b1;
            d.addr = `ACTFW_ATA_DATA;
            if (be == `ACTFW_BE_8) begin
               d.size = `ACTFW_SZ_8;
            end else if (be == (cb ? `ACTFW_BE_16_CB : `ACTFW_BE_16)) begin
               d.size = `ACTFW_SZ_16; // [R14]
            end else if (be == `ACTFW_BE_32) begin
               d.size = `ACTFW_SZ_32;
            end else begin
               d.isData = 1'b0;
               d.size = `ACTFW_SZ_BYTE;
               // Base needs a lone lane, alias only the named one
               if (cb ? be[3] : (be == 4'h8)) begin
                  d.addr = `ACTFW_ATA_SNUM; // [R5] [R15]
                  d.lane = 2'h3;
               end else if (cb ? be[2] : (be == 4'h4)) begin
                  d.addr = `ACTFW_ATA_SCNT; // [R5] [R15]
                  d.lane = 2'h2;
               end else if (cb ? be[1] : (be == 4'h2)) begin
                  d.addr = `ACTFW_ATA_FEAT; // [R6] [R15]
                  d.lane = 2'h1;
               end else begin
                  d.ok = 1'b0;
               end
            end
         end
         `ACTFW_TF_B_OFF, `ACTFW_CB_B_OFF: begin
            d.ok = single; // [R7]
            d.lane = laneOf(be);
            d.addr = {1'b1, laneOf(be)}; // [R8] [R9]
            d.size = `ACTFW_SZ_BYTE;
         end
         `ACTFW_TF_CTL_OFF: begin
            d.ok = single; // [R7]
            d.rsvd = (be != 4'h4); // [R11]
            d.ctl = 1'b1;
            d.addr = `ACTFW_ATA_DEVCTL; // [R10]
            d.lane = 2'h2;
            d.size = `ACTFW_SZ_BYTE;
         end
         `ACTFW_RA_DATA_OFF: begin
            d.ok = (be == `ACTFW_BE_8) || (be == `ACTFW_BE_16) ||
                   (be == `ACTFW_BE_32); // [R12]
            d.isData = 1'b1;
            d.addr = `ACTFW_ATA_DATA;
            d.size = (be == `ACTFW_BE_8) ? `ACTFW_SZ_8 :
                     (be == `ACTFW_BE_16) ? `ACTFW_SZ_16 : `ACTFW_SZ_32;
         end
         default: begin
            d.ok = 1'b0;
         end
      endcase
      decodeAccess = d;
   endfunction : decodeAccess

   // ====
   // Next state
   always_comb begin
      dec = decodeAccess(link.addr, link.be);
      devNext = devReg;
      devNext.ack = 1'b0;
      devNext.err = 1'b0;
      case (devReg.state)
         DV_IDLE: begin
            // Ack still high means this request was just served
            if (link.req && !devReg.ack) begin
               if (!dec.ok) begin
                  devNext.ack = 1'b1;
                  devNext.err = 1'b1;
                  devNext.rdata = `ACTFW_TF_RESET;
               end else if (dec.rsvd) begin
                  devNext.ack = 1'b1;
                  devNext.rdata = `ACTFW_TF_RESET; // [R11]
               end else if (dec.buffered && link.wr && !dec.isData) begin
                  devNext.ack = 1'b1;
                  devNext.rdata = `ACTFW_TF_RESET;
                  if (devReg.bufCount == `ACTFW_BUF_DEPTH) begin
                     devNext.err = 1'b1;
                  end else begin
                     devNext.cmdBuf[devReg.bufCount[2:0]] =
                        {dec.addr, laneDown(link.wdata, dec.lane)}; // [R13]
                     devNext.bufCount = devReg.bufCount + 4'h1;
                     if (dec.addr == `ACTFW_ATA_CMD) begin
                        devNext.bufActive = 1'b1; // [R16]
                        devNext.bufIdx = 4'h0;
                        devNext.state = DV_DRAIN;
                     end
                  end
               end else begin
                  devNext.ataReq = 1'b1; // [R17]
                  devNext.ataWr = link.wr;
                  devNext.ataCtl = dec.ctl;
                  devNext.ataAddr = dec.addr;
                  devNext.ataSize = dec.size;
                  devNext.lane = dec.lane;
                  devNext.isData = dec.isData;
                  devNext.ataWdata = dec.isData ?
                     maskData(dec.size, link.wdata) :
                     {24'h00_0000, laneDown(link.wdata, dec.lane)};
                  devNext.state = DV_ATA;
               end
            end
         end
         DV_ATA: begin
            if (ataAck) begin
               devNext.ataReq = 1'b0;
               devNext.ack = 1'b1;
               // Read side of a shared lane: error, status, aux status
               devNext.rdata = devReg.isData ?
                  maskData(devReg.ataSize, ataRdata) :
                  laneUp(ataRdata[7:0], devReg.lane); // [R6] [R8] [R10]
               devNext.state = DV_IDLE;
            end
         end
         DV_DRAIN: begin
            // New requests wait here until the drive has every byte
            if (devReg.ataReq) begin
               if (ataAck) begin
                  devNext.ataReq = 1'b0;
                  devNext.bufIdx = devReg.bufIdx + 4'h1;
               end
            end else if (devReg.bufIdx == devReg.bufCount) begin
               devNext.bufActive = 1'b0; // [R16]
               devNext.bufCount = 4'h0;
               devNext.state = DV_IDLE;
            end else begin
               devNext.ataReq = 1'b1; // [R17]
               devNext.ataWr = 1'b1;
               devNext.ataCtl = 1'b0;
               devNext.ataSize = `ACTFW_SZ_BYTE;
               devNext.ataAddr = devReg.cmdBuf[devReg.bufIdx[2:0]][10:8];
               devNext.ataWdata =
                  {24'h00_0000, devReg.cmdBuf[devReg.bufIdx[2:0]][7:0]};
            end
         end
         default: begin
            devNext = DEV_RESET;
         end
      endcase
   end

   // ====
   // Registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         devReg <= DEV_RESET;
      end else begin
         devReg <= devNext;
      end
   end

   // ====
   // Outputs
   assign link.ack = devReg.ack;
   assign link.err = devReg.err;
   assign link.rdata = devReg.rdata;
   assign ataReq = devReg.ataReq;
   assign ataWr = devReg.ataWr;
   assign ataCtl = devReg.ataCtl;
   assign ataAddr = devReg.ataAddr;
   assign ataSize = devReg.ataSize;
   assign ataWdata = devReg.ataWdata;
   assign bufferedActive = devReg.bufActive;

endmodule : actfw_device

// *** hw/actfw_host.sv ***
// Purpose: host end issuing target accesses to the task file window
// Assumes: software posts one access at a time over APB
// Notes: pready answers in the first access cycle, no wait states
`timescale 1ns/1ps
module actfw_host
   import actfw_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Target link
   actfw_if.host link
);

   // ====
   // State
   typedef struct packed {
      actfw_host_state_t state;
      logic req;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
      logic [1:0] size;
      logic [1:0] lane;
      logic [31:0] wdataSw;
      logic [31:0] rdataSw;
      logic busy;
      logic err;
      logic ready;
      logic slvErr;
      logic [31:0] prdata;
   } actfw_host_t;

   localparam actfw_host_t HOST_RESET = '{state: HS_IDLE, default: '0};

   actfw_host_t hostReg;
   actfw_host_t hostNext;

   // ====
   // Lane selection
   function automatic logic [3:0] buildBe(input logic [7:0] off,
                                          input logic [1:0] size,
                                          input logic [1:0] lane);
      case (size)
         `ACTFW_SZ_8: buildBe = `ACTFW_BE_8; // [R1]
         `ACTFW_SZ_16: buildBe = (off == `ACTFW_CB_A_OFF) ?
                                 `ACTFW_BE_16_CB : `ACTFW_BE_16; // [R2] [R14]
         `ACTFW_SZ_32: buildBe = `ACTFW_BE_32; // [R3]
         default: buildBe = 4'h1 << lane;
      endcase
   endfunction : buildBe

   // ====
   // Next state
   always_comb begin
      hostNext = hostReg;
      hostNext.ready = 1'b0;
      hostNext.slvErr = 1'b0;
      if (psel && !penable) begin
         hostNext.ready = 1'b1;
         case (paddr)
            `ACTFW_APB_CMD: hostNext.prdata = {24'h00_0000, hostReg.addr};
            `ACTFW_APB_WDATA: hostNext.prdata = hostReg.wdataSw;
            `ACTFW_APB_RDATA: hostNext.prdata = hostReg.rdataSw;
            `ACTFW_APB_STAT: hostNext.prdata = {30'h0, hostReg.err,
                                                hostReg.busy};
            default: begin
               hostNext.prdata = 32'h0000_0000;
               hostNext.slvErr = 1'b1;
            end
         endcase
      end
      if (psel && penable && hostReg.ready && pwrite) begin
         if (paddr == `ACTFW_APB_WDATA) begin
            hostNext.wdataSw = pwdata;
         end
         // A start while busy is dropped
         if ((paddr == `ACTFW_APB_CMD) && pwdata[`ACTFW_CMD_START_BIT] &&
             !hostReg.busy) begin
            hostNext.addr = pwdata[7:0];
            hostNext.size = pwdata[`ACTFW_CMD_SIZE_LSB +: 2];
            hostNext.lane = pwdata[`ACTFW_CMD_LANE_LSB +: 2];
            hostNext.wr = pwdata[`ACTFW_CMD_WR_BIT];
            hostNext.be = buildBe(pwdata[7:0],
                                  pwdata[`ACTFW_CMD_SIZE_LSB +: 2],
                                  pwdata[`ACTFW_CMD_LANE_LSB +: 2]);
            hostNext.wdata = (pwdata[`ACTFW_CMD_SIZE_LSB +: 2] ==
                              `ACTFW_SZ_BYTE) ?
               laneUp(hostReg.wdataSw[7:0],
                      pwdata[`ACTFW_CMD_LANE_LSB +: 2]) :
               maskData(pwdata[`ACTFW_CMD_SIZE_LSB +: 2],
                        hostReg.wdataSw); // [R4]
            hostNext.busy = 1'b1;
            hostNext.req = 1'b1;
            hostNext.state = HS_REQ;
         end
      end
      case (hostReg.state)
         HS_IDLE: begin
         end
         HS_REQ: begin
            if (link.ack) begin
               hostNext.req = 1'b0;
               hostNext.busy = 1'b0;
               hostNext.err = link.err;
               hostNext.rdataSw = (hostReg.size == `ACTFW_SZ_BYTE) ?
                  {24'h00_0000, laneDown(link.rdata, hostReg.lane)} :
                  link.rdata;
               hostNext.state = HS_IDLE;
            end
         end
         default: begin
            hostNext = HOST_RESET;
         end
      endcase
   end

   // ====
   // Registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hostReg <= HOST_RESET;
      end else begin
         hostReg <= hostNext;
      end
   end

   // ====
   // Outputs
   assign prdata = hostReg.prdata;
   assign pready = hostReg.ready;
   assign pslverr = hostReg.slvErr;
   assign link.req = hostReg.req;
   assign link.wr = hostReg.wr;
   assign link.addr = hostReg.addr;
   assign link.be = hostReg.be;
   assign link.wdata = hostReg.wdata;

endmodule : actfw_host

// *** hw/actfw_if.sv ***
// Purpose: target link between host end and task file window
// Assumes: one clock shared by both ends
// Notes: request held until a one-cycle ack
`timescale 1ns/1ps
interface actfw_if;
   logic req;
   logic wr;
   logic [7:0] addr;
   logic [3:0] be;
   logic [31:0] wdata;
   logic ack;
   logic err;
   logic [31:0] rdata;

   modport host (output req, wr, addr, be, wdata,
                 input ack, err, rdata);
   modport dev (input req, wr, addr, be, wdata,
                output ack, err, rdata);
endinterface : actfw_if

// *** hw/actfw_params.svh ***
// Purpose: constants of the channel-1 task file window and its host end
// Assumes: offsets are byte addresses on the target side
// Notes: types and shared functions live in actfw_pkg
//
// What this block does
// (R1) Host uses lane 0 alone for 8-bit data
// (R2) Host uses lanes 1,0 for 16-bit data
// (R3) Host uses all lanes for 32-bit data
// (R4) Host writes data zero-aligned from lane 0
// (R5) Sector number/count on single lane 3/2
// (R6) Lane 1: write features, read error
// (R7) Second, third offsets need exactly one lane
// (R8) Lane 3: write command, read status
// (R9) Device/head, cylinder high/low read-write lanes
// (R10) Lane 2: write devctl, read aux status
// (R11) Reserved control-window bits read as zero
// (R12) Read-ahead port takes 8/16/32-bit accesses
// (R13) Buffered alias at D0, D4, same layout
// (R14) Alias 16-bit data uses lanes 1 and 3
// (R15) Alias fields chosen by lane 3, 2, 1
// (R16) Buffered flag: command register byte queued to drained
// (R17) Each granted access makes one drive cycle, except reserved control-window accesses, which make none
`ifndef ACTFW_PARAMS_SVH
`define ACTFW_PARAMS_SVH

// ====
// Window offsets
`define ACTFW_TF_A_OFF 8'hC0
`define ACTFW_TF_B_OFF 8'hC4
`define ACTFW_TF_CTL_OFF 8'hC8
`define ACTFW_RA_DATA_OFF 8'hCC
`define ACTFW_CB_A_OFF 8'hD0
`define ACTFW_CB_B_OFF 8'hD4
`define ACTFW_TF_RESET 32'h0000_0000

// ====
// Byte enable patterns of data accesses
`define ACTFW_BE_8 4'h1
`define ACTFW_BE_16 4'h3
`define ACTFW_BE_16_CB 4'hA
`define ACTFW_BE_32 4'hF

// ====
// Drive register addresses and access sizes
`define ACTFW_ATA_DATA 3'h0
`define ACTFW_ATA_FEAT 3'h1
`define ACTFW_ATA_SCNT 3'h2
`define ACTFW_ATA_SNUM 3'h3
`define ACTFW_ATA_DEVCTL 3'h6
`define ACTFW_ATA_CMD 3'h7
`define ACTFW_SZ_BYTE 2'h0
`define ACTFW_SZ_8 2'h1
`define ACTFW_SZ_16 2'h2
`define ACTFW_SZ_32 2'h3
`define ACTFW_BUF_DEPTH 4'h8

// ====
// Host APB registers and fields
`define ACTFW_APB_CMD 8'h00
`define ACTFW_APB_WDATA 8'h04
`define ACTFW_APB_RDATA 8'h08
`define ACTFW_APB_STAT 8'h0C
`define ACTFW_CMD_START_BIT 31
`define ACTFW_CMD_WR_BIT 12
`define ACTFW_CMD_LANE_LSB 10
`define ACTFW_CMD_SIZE_LSB 8
`define ACTFW_STAT_BUSY_BIT 0
`define ACTFW_STAT_ERR_BIT 1

`endif

// *** hw/actfw_pkg.sv ***
// Purpose: types and shared helpers of the task file window
// Assumes: actfw_params.svh defines the constants
// Notes: none
`include "actfw_params.svh"
package actfw_pkg;

   // ====
   // States
   typedef enum logic [2:0] {
      DV_IDLE = 3'b001,
      DV_ATA = 3'b010,
      DV_DRAIN = 3'b100
   } actfw_dev_state_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b01,
      HS_REQ = 2'b10
   } actfw_host_state_t;

   // ====
   // Decoded target access
   typedef struct packed {
      logic ok;
      logic rsvd;
      logic isData;
      logic buffered;
      logic ctl;
      logic [2:0] addr;
      logic [1:0] lane;
      logic [1:0] size;
   } actfw_dec_t;

   // ====
   // Helpers
   function automatic logic [31:0] maskData(input logic [1:0] size,
                                             input logic [31:0] val);
      case (size)
         `ACTFW_SZ_8: maskData = val & 32'h0000_00FF;
         `ACTFW_SZ_16: maskData = val & 32'h0000_FFFF;
         default: maskData = val;
      endcase
   endfunction : maskData

   function automatic logic [31:0] laneUp(input logic [7:0] b,
                                           input logic [1:0] lane);
      laneUp = {24'h00_0000, b} << {lane, 3'b000};
   endfunction : laneUp

   function automatic logic [7:0] laneDown(input logic [31:0] w,
                                            input logic [1:0] lane);
      logic [31:0] s;
      s = w >> {lane, 3'b000};
      laneDown = s[7:0];
   endfunction : laneDown

endpackage : actfw_pkg

// *** tb/actfw_link_chk.sv ***
// Purpose: link checks between host end and task file window
// Assumes: all link signals sampled on the rising clock edge
// Notes: instantiated beside the link in tb_top
`timescale 1ns/1ps
`include "actfw_params.svh"
module actfw_link_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Link
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [3:0] be,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic err,
   input wire logic [31:0] rdata
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ====
   // Handshake
   sequence sWait;
      req && !ack;
   endsequence
   sequence sHold;
      req && $stable({wr, addr, be, wdata});
   endsequence
   sequence sReleased;
      !ack && !req;
   endsequence
   AST_REQ_HOLD: assert property (sWait |=> sHold)
      else $error("request changed before ack");
   AST_ACK_RELEASE: assert property (ack |=> sReleased)
      else $error("ack or request not released");
   AST_ACK_BOUND: assert property ($rose(req) |-> ##[1:300] ack)
      else $error("request never answered");
   AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
      else $error("rdata changed without ack");
   AST_ERR_ONLY_ACK: assert property (err |-> ack && req)
      else $error("err outside an answer");
   // ====
   // Lane decoding
   AST_C0_LEGAL: assert property (ack && addr == `ACTFW_TF_A_OFF
      && be inside {4'h1, 4'h3, 4'hF, 4'h8, 4'h4, 4'h2} |-> !err)
      else $error("legal base access refused");
   AST_MULTI_LANE: assert property (ack && !$onehot(be)
      && (addr == `ACTFW_TF_B_OFF || addr == `ACTFW_TF_CTL_OFF)
      |-> err && rdata == 32'h0000_0000)
      else $error("multi-lane field access not refused");
   AST_CTL_RSVD: assert property (ack && !wr
      && addr == `ACTFW_TF_CTL_OFF
      |-> rdata[31:24] == 8'h00 && rdata[15:0] == 16'h0000)
      else $error("reserved control bits not zero");
   AST_DATA8: assert property (ack && !wr && !err && be == 4'h1
      && addr inside {`ACTFW_TF_A_OFF, `ACTFW_RA_DATA_OFF, `ACTFW_CB_A_OFF}
      |-> rdata[31:8] == 24'h00_0000)
      else $error("8-bit data read not masked");
   AST_CB16: assert property (ack && !wr && !err && be == 4'hA
      && addr == `ACTFW_CB_A_OFF |-> rdata[31:16] == 16'h0000)
      else $error("alias 16-bit read not zero-aligned");
   cover property (ack && err);
endmodule : actfw_link_chk

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of host end and task file window
// Assumes: drive side answers each cycle one clock after request
// Notes: field reads come back in the low byte of RDATA
`timescale 1ns/1ps
`include "actfw_params.svh"
module tb_top;
   localparam logic [7:0] C0 = `ACTFW_TF_A_OFF, C4 = `ACTFW_TF_B_OFF;
   localparam logic [7:0] C8 = `ACTFW_TF_CTL_OFF, CC = `ACTFW_RA_DATA_OFF;
   localparam logic [7:0] D0 = `ACTFW_CB_A_OFF, D4 = `ACTFW_CB_B_OFF;
   localparam logic [1:0] SB = `ACTFW_SZ_BYTE, S8 = `ACTFW_SZ_8;
   localparam logic [1:0] S16 = `ACTFW_SZ_16, S32 = `ACTFW_SZ_32;
   localparam logic [7:0] ERRV = 8'h5A, STATV = 8'h58, AUXV = 8'hD1;
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, ataWdata, ataRdata;
   logic ataReq, ataWr, ataCtl, bufferedActive;
   logic ataAck = 1'b0;
   logic [2:0] ataAddr;
   logic [1:0] ataSize;
   logic [31:0] driveMem [8];
   logic [38:0] cycQ [$];
   int err_total, num_checks, bufCnt;
   actfw_if link();
   actfw_host i_actfw_host(.sys_clk(sys_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   actfw_device i_actfw_device(.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link), .ataReq(ataReq), .ataWr(ataWr), .ataCtl(ataCtl),
      .ataAddr(ataAddr), .ataSize(ataSize), .ataWdata(ataWdata),
      .ataAck(ataAck), .ataRdata(ataRdata),
      .bufferedActive(bufferedActive));
   actfw_link_chk i_actfw_link_chk(.sys_clk(sys_clk), .sys_rst(sys_rst),
      .req(link.req), .wr(link.wr), .addr(link.addr), .be(link.be),
      .wdata(link.wdata), .ack(link.ack), .err(link.err),
      .rdata(link.rdata));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ====
   // Drive side: error, status, aux status read as fixed values
   assign ataRdata = ataCtl ? {24'h0, AUXV} :
      (ataAddr == `ACTFW_ATA_FEAT) ? {24'h0, ERRV} :
      (ataAddr == `ACTFW_ATA_CMD) ? {24'h0, STATV} : driveMem[ataAddr];
   always @(posedge sys_clk) begin
      ataAck <= ataReq && !ataAck;
      if (bufferedActive === 1'b1) bufCnt <= bufCnt + 1;
      if (ataReq && ataAck) begin
         cycQ.push_back({ataCtl, ataWr, ataAddr, ataSize, ataWdata});
         if (ataWr && !ataCtl) driveMem[ataAddr] <= ataWdata;
      end
   end
   // ====
   // Compare and bus tasks
   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chkVal
   task automatic chkCyc(input logic [6:0] exp, input logic [31:0] wd);
      logic [38:0] g;
      g = (cycQ.size() > 0) ? cycQ.pop_front() : 'x;
      chkVal({25'h0, g[38:32]}, {25'h0, exp});
      if (exp[5]) chkVal(g[31:0], wd);
   endtask : chkCyc
   function automatic logic [6:0] cy(input logic c, input logic w,
                                     input logic [2:0] a,
                                     input logic [1:0] s);
      return {c, w, a, s};
   endfunction : cy
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic e);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One window access posted through the host registers
   task automatic run(input logic [7:0] off, input logic [1:0] sz,
                      input logic [1:0] ln, input logic w,
                      input logic [31:0] d, input logic [31:0] expR,
                      input logic expE);
      logic [31:0] st, rd;
      logic pe;
      int n;
      apb(1'b1, `ACTFW_APB_WDATA, d, st, pe);
      apb(1'b1, `ACTFW_APB_CMD, {1'b1, 18'h0, w, ln, sz, off}, st, pe);
      n = 0;
      do begin
         apb(1'b0, `ACTFW_APB_STAT, 32'h0, st, pe);
         n++;
      end while (st[0] !== 1'b0 && n < 400);
      apb(1'b0, `ACTFW_APB_RDATA, 32'h0, rd, pe);
      chkVal({30'h0, st[1:0]}, {30'h0, expE, 1'b0});
      if (!w && !expE) chkVal(rd, expR);
   endtask : run
   // ====
   // Scenarios
   task automatic tRegs;
      logic [31:0] rd;
      logic e;
      apb(1'b0, `ACTFW_APB_STAT, 32'h0, rd, e);
      chkVal(rd, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0, rd, e);
      chkVal({e, rd[30:0]}, 32'h8000_0000);
   endtask : tRegs
   task automatic tData;
      logic [7:0] o;
      for (int i = 0; i < 2; i++) begin
         o = (i == 0) ? C0 : CC;
         run(o, S32, 2'h0, 1'b1, 32'hA1B2_C3D4, 32'h0, 1'b0);
         chkCyc(cy(1'b0, 1'b1, 3'h0, S32), 32'hA1B2_C3D4);
         run(o, S32, 2'h0, 1'b0, 32'h0, 32'hA1B2_C3D4, 1'b0);
         chkCyc(cy(1'b0, 1'b0, 3'h0, S32), 32'h0);
         run(o, S16, 2'h0, 1'b0, 32'h0, 32'h0000_C3D4, 1'b0);
         chkCyc(cy(1'b0, 1'b0, 3'h0, S16), 32'h0);
         run(o, S8, 2'h0, 1'b0, 32'h0, 32'h0000_00D4, 1'b0);
         chkCyc(cy(1'b0, 1'b0, 3'h0, S8), 32'h0);
         run(o, S8, 2'h0, 1'b1, 32'h0000_00E7, 32'h0, 1'b0);
         chkCyc(cy(1'b0, 1'b1, 3'h0, S8), 32'h0000_00E7);
      end
   endtask : tData
   task automatic tFields;
      logic [7:0] v, x;
      for (int i = 1; i < 4; i++) begin
         v = 8'h10 + 8'(i);
         x = (i == 1) ? ERRV : v;
         run(C0, SB, 2'(i), 1'b1, {24'h0, v}, 32'h0, 1'b0);
         chkCyc(cy(1'b0, 1'b1, 3'(i), SB), {24'h0, v});
         run(C0, SB, 2'(i), 1'b0, 32'h0, {24'h0, x}, 1'b0);
         chkCyc(cy(1'b0, 1'b0, 3'(i), SB), 32'h0);
      end
   endtask : tFields
   task automatic tC4C8;
      logic [7:0] v;
      for (int i = 0; i < 3; i++) begin
         v = 8'h40 + 8'(i);
         run(C4, SB, 2'(i), 1'b1, {24'h0, v}, 32'h0, 1'b0);
         chkCyc(cy(1'b0, 1'b1, 3'(4 + i), SB), {24'h0, v});
         run(C4, SB, 2'(i), 1'b0, 32'h0, {24'h0, v}, 1'b0);
         chkCyc(cy(1'b0, 1'b0, 3'(4 + i), SB), 32'h0);
      end
      run(C4, SB, 2'h3, 1'b1, 32'h0000_00EC, 32'h0, 1'b0);
      chkCyc(cy(1'b0, 1'b1, `ACTFW_ATA_CMD, SB), 32'h0000_00EC);
      run(C4, SB, 2'h3, 1'b0, 32'h0, {24'h0, STATV}, 1'b0);
      chkCyc(cy(1'b0, 1'b0, `ACTFW_ATA_CMD, SB), 32'h0);
      run(C4, S16, 2'h0, 1'b0, 32'h0, 32'h0, 1'b1);
      run(C8, SB, 2'h2, 1'b1, 32'h0000_0002, 32'h0, 1'b0);
      chkCyc(cy(1'b1, 1'b1, `ACTFW_ATA_DEVCTL, SB), 32'h2);
      run(C8, SB, 2'h2, 1'b0, 32'h0, {24'h0, AUXV}, 1'b0);
      chkCyc(cy(1'b1, 1'b0, `ACTFW_ATA_DEVCTL, SB), 32'h0);
      run(C8, SB, 2'h0, 1'b0, 32'h0, 32'h0, 1'b0);
      run(C8, SB, 2'h3, 1'b0, 32'h0, 32'h0, 1'b0);
      run(C8, S32, 2'h0, 1'b0, 32'h0, 32'h0, 1'b1);
      chkVal(32'(cycQ.size()), 32'h0);
   endtask : tC4C8
   task automatic tBuf;
      int b, n;
      run(CC, S32, 2'h0, 1'b1, 32'h1234_5678, 32'h0, 1'b0);
      chkCyc(cy(1'b0, 1'b1, 3'h0, S32), 32'h1234_5678);
      run(D0, S16, 2'h0, 1'b0, 32'h0, 32'h0000_5678, 1'b0);
      chkCyc(cy(1'b0, 1'b0, 3'h0, S16), 32'h0);
      run(D0, SB, 2'h2, 1'b1, 32'h0000_0007, 32'h0, 1'b0);
      run(D4, SB, 2'h2, 1'b1, 32'h0000_00A0, 32'h0, 1'b0);
      chkVal(32'(cycQ.size()), 32'h0);
      chkVal({31'h0, bufferedActive}, 32'h0);
      b = bufCnt;
      run(D4, SB, 2'h3, 1'b1, 32'h0000_0020, 32'h0, 1'b0);
      n = 0;
      while (bufferedActive !== 1'b0 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      chkVal({31'h0, bufCnt > b}, 32'h1);
      chkCyc(cy(1'b0, 1'b1, `ACTFW_ATA_SCNT, SB), 32'h7);
      chkCyc(cy(1'b0, 1'b1, 3'h6, SB), 32'hA0);
      chkCyc(cy(1'b0, 1'b1, `ACTFW_ATA_CMD, SB), 32'h20);
      run(D0, SB, 2'h2, 1'b0, 32'h0, 32'h0000_0007, 1'b0);
      chkCyc(cy(1'b0, 1'b0, `ACTFW_ATA_SCNT, SB), 32'h0);
   endtask : tBuf
   task automatic conclude;
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_total = 0;
      num_checks = 0;
      bufCnt = 0;
      foreach (driveMem[i]) driveMem[i] = 32'h0;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      tRegs;
      tData;
      tFields;
      tC4C8;
      tBuf;
      conclude;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #(25 * 40000);
      err_total++;
      conclude;
   end
endmodule : tb_top
